// *** rdf_config_bank.sv ***
// Deviation, after-transmit, auto calibration and power-on timeout configuration
// Functional notes
// - FSK deviation is (8+mantissa) shifted by exponent
// - Under MSK mantissa is phase-change fraction
// - Reset exponent 4, mantissa 7
// - Packet done selects idle, synth-on or transmit
// - Autocal modes never, to transmit, to idle
// - Mode 3 calibrates every fourth transmit-to-idle
// - Ripple wraps counted before chip ready low
// - Wrap counts 1, 16, 64, 256
// - Timeout field survives sleep power-down
`timescale 1ns/10ps
module rdf_config_bank (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic [rdf_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic                        reg_wr_en,
	input  wire logic [7:0]                  reg_wr_data,
	output logic      [7:0]                  reg_rd_data,
	input  wire logic                        msk_select,
	input  wire logic                        packet_tx_done,
	input  wire logic                        idle_to_tx,
	input  wire logic                        tx_to_idle,
	input  wire logic                        calibrate_strobe,
	input  wire logic                        sleep_enter,
	input  wire logic                        xosc_running,
	output logic      [10:0]                 deviation_steps,
	output logic      [2:0]                  msk_phase_fraction,
	output rdf_pkg::rdf_next_t               after_transmit_next_state,
	output logic                             next_state_valid,
	output logic                             synth_calibrate,
	output logic                             chip_ready_low
);
	import rdf_pkg::*;

	typedef struct packed {
		logic [2:0]          dev_e;
		logic [2:0]          dev_m;
		logic [1:0]          txoff;
		logic [1:0]          autocal;
		logic [1:0]          power_on_timeout;
		logic [7:0]          rd_data;
		logic [10:0]         dev_steps;
		logic [2:0]          msk_frac;
		logic [1:0]          cal_count;
		logic                cal_pulse;
		logic                next_valid;
		logic [1:0]          next_state;
		logic                xosc_meta;
		logic                xosc_sync;
		logic [RIPPLE_W-1:0] ripple;
		logic [EXPIRE_W-1:0] expires;
		logic                ready;
	} rdf_state_t;

	rdf_state_t state_reg;
	rdf_state_t state_next;

	// Wrap count needed for each timeout setting
	function automatic logic [EXPIRE_W-1:0] expire_target(input logic [1:0] sel);
		unique case (sel)
			2'h0: expire_target = EXPIRE_0;
			2'h1: expire_target = EXPIRE_1;
			2'h2: expire_target = EXPIRE_2;
			2'h3: expire_target = EXPIRE_3;
		endcase
	endfunction : expire_target

	// Next state of the whole bank
	always_comb begin
		state_next = state_reg;
		state_next.cal_pulse = 1'b0;
		state_next.next_valid = 1'b0;

		// Register writes; reserved bit positions are simply not stored
		if (reg_wr_en) begin
			unique case (reg_addr)
				ADDR_FREQUENCY_DEVIATION_SETTING: begin
					state_next.dev_e = reg_wr_data[DEV_E_LSB +: 3];
					state_next.dev_m = reg_wr_data[DEV_M_LSB +: 3];
				end
				ADDR_STATE_MACHINE_CONFIG_ONE: begin
					state_next.txoff = reg_wr_data[TXOFF_LSB +: 2];
				end
				ADDR_STATE_MACHINE_CONFIG_ZERO: begin
					state_next.autocal = reg_wr_data[AUTOCAL_LSB +: 2];
					state_next.power_on_timeout = reg_wr_data[POWER_ON_TIMEOUT_LSB +: 2];
				end
				default: begin
				end
			endcase
		end

		// Sleep drops the configuration but keeps the timeout to speed wake-up
		if (sleep_enter) begin
			state_next.dev_e = DEV_E_RST;
			state_next.dev_m = DEV_M_RST;
			state_next.txoff = TXOFF_RST;
			state_next.autocal = AUTOCAL_RST;
			state_next.cal_count = 2'h0;
		end

		// Read-back, reserved bits as zero, unmapped addresses read zero
		state_next.rd_data = 8'h00;
		unique case (reg_addr)
			ADDR_FREQUENCY_DEVIATION_SETTING: begin
				state_next.rd_data[DEV_E_LSB +: 3] = state_reg.dev_e;
				state_next.rd_data[DEV_M_LSB +: 3] = state_reg.dev_m;
			end
			ADDR_STATE_MACHINE_CONFIG_ONE: begin
				state_next.rd_data[TXOFF_LSB +: 2] = state_reg.txoff;
			end
			ADDR_STATE_MACHINE_CONFIG_ZERO: begin
				state_next.rd_data[AUTOCAL_LSB +: 2] = state_reg.autocal;
				state_next.rd_data[POWER_ON_TIMEOUT_LSB +: 2] = state_reg.power_on_timeout;
			end
			default: begin
			end
		endcase

		// Deviation word or MSK phase fraction, chosen by modulation
		if (msk_select) begin
			state_next.dev_steps = 11'h000;
			state_next.msk_frac = state_reg.dev_m;
		end else begin
			state_next.dev_steps = 11'({DEV_M_IMPLICIT | {1'b0, state_reg.dev_m}})
				<< state_reg.dev_e;
			state_next.msk_frac = 3'h0;
		end

		// Next state after a packet; value 3 is left to the host to avoid
		if (packet_tx_done) begin
			state_next.next_valid = 1'b1;
			state_next.next_state = state_reg.txoff;
		end

		// Automatic and manual synthesizer calibration
		if (calibrate_strobe) begin
			state_next.cal_pulse = 1'b1;
		end
		unique case (rdf_cal_t'(state_reg.autocal))
			RDF_CAL_NEVER: begin
			end
			RDF_CAL_TO_TX: begin
				if (idle_to_tx) begin
					state_next.cal_pulse = 1'b1;
				end
			end
			RDF_CAL_TO_IDLE: begin
				if (tx_to_idle) begin
					state_next.cal_pulse = 1'b1;
				end
			end
			RDF_CAL_FOURTH: begin
				if (tx_to_idle) begin
					state_next.cal_count = state_reg.cal_count + 2'h1;
					if (state_reg.cal_count == CAL_EVERY_LAST) begin
						state_next.cal_pulse = 1'b1;
					end
				end
			end
		endcase

		// Crystal state crosses from the pin through two flops
		state_next.xosc_meta = xosc_running;
		state_next.xosc_sync = state_reg.xosc_meta;

		// Power-on timeout: count ripple wraps after the crystal starts
		if (!state_reg.xosc_sync) begin
			state_next.ripple = '0;
			state_next.expires = '0;
			state_next.ready = 1'b0;
		end else if (!state_reg.ready) begin
			state_next.ripple = state_reg.ripple + 6'h01;
			if (state_reg.ripple == '1) begin
				state_next.expires = state_reg.expires + 9'h001;
				if (state_reg.expires + 9'h001 == expire_target(state_reg.power_on_timeout)) begin
					state_next.ready = 1'b1;
				end
			end
		end
	end

	// Single register stage for the whole bank
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= '0;
			state_reg.dev_e <= DEV_E_RST;
			state_reg.dev_m <= DEV_M_RST;
			state_reg.txoff <= TXOFF_RST;
			state_reg.autocal <= AUTOCAL_RST;
			state_reg.power_on_timeout <= POWER_ON_TIMEOUT_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from flops
	assign reg_rd_data = state_reg.rd_data;
	assign deviation_steps = state_reg.dev_steps;
	assign msk_phase_fraction = state_reg.msk_frac;
	assign after_transmit_next_state = rdf_next_t'(state_reg.next_state);
	assign next_state_valid = state_reg.next_valid;
	assign synth_calibrate = state_reg.cal_pulse;
	assign chip_ready_low = ~state_reg.ready;

	property p_reset_dev;
		@(posedge clk) $past(rst) |-> (state_reg.dev_e == 3'h4 && state_reg.dev_m == 3'h7);
	endproperty
	a_reset_dev: assert property (p_reset_dev) else $error("deviation reset wrong");

	property p_fsk_dev;
		@(posedge clk) disable iff (rst)
			(!msk_select && !reg_wr_en && !sleep_enter) ##1 (!reg_wr_en && !sleep_enter)
			|-> ##1 deviation_steps == ($past(msk_select) ? 11'h000
				: (11'({1'b1, $past(state_reg.dev_m, 1)}) << state_reg.dev_e));
	endproperty
	a_fsk_dev: assert property (p_fsk_dev) else $error("deviation word wrong");

	property p_msk;
		@(posedge clk) disable iff (rst)
			msk_select |=> (deviation_steps == 11'h000 && msk_phase_fraction == $past(state_reg.dev_m));
	endproperty
	a_msk: assert property (p_msk) else $error("msk fraction wrong");

	property p_next_state;
		@(posedge clk) disable iff (rst)
			packet_tx_done |=> (next_state_valid && after_transmit_next_state == $past(state_reg.txoff));
	endproperty
	a_next_state: assert property (p_next_state) else $error("after transmit state wrong");

	property p_cal_never;
		@(posedge clk) disable iff (rst)
			(state_reg.autocal == 2'h0 && !calibrate_strobe) |=> !synth_calibrate;
	endproperty
	a_cal_never: assert property (p_cal_never) else $error("calibration without cause");

	property p_cal_idle;
		@(posedge clk) disable iff (rst)
			(state_reg.autocal == 2'h2 && tx_to_idle) |=> synth_calibrate;
	endproperty
	a_cal_idle: assert property (p_cal_idle) else $error("missing idle calibration");

	property p_cal_fourth;
		@(posedge clk) disable iff (rst)
			(state_reg.autocal == 2'h3 && tx_to_idle && !calibrate_strobe && !sleep_enter)
			|=> synth_calibrate == ($past(state_reg.cal_count) == 2'h3);
	endproperty
	a_cal_fourth: assert property (p_cal_fourth) else $error("fourth calibration wrong");

	property p_ready;
		@(posedge clk) disable iff (rst)
			$fell(chip_ready_low) |-> ($past(state_reg.expires) + 9'h001
				== expire_target($past(state_reg.power_on_timeout)) && state_reg.xosc_sync);
	endproperty
	a_ready: assert property (p_ready) else $error("chip ready at wrong count");

	property p_sleep_keep;
		@(posedge clk) disable iff (rst)
			(sleep_enter && !reg_wr_en) |=> $stable(state_reg.power_on_timeout);
	endproperty
	a_sleep_keep: assert property (p_sleep_keep) else $error("timeout lost in sleep");

	property p_reserved;
		@(posedge clk) disable iff (rst)
			(reg_addr == ADDR_FREQUENCY_DEVIATION_SETTING) |=> (reg_rd_data[7] == 1'b0
				&& reg_rd_data[3] == 1'b0);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
endmodule : rdf_config_bank

// *** rdf_host_model.sv ***
// Host controller model driving the register strobes
`timescale 1ns/10ps
module rdf_host_model (
	input  wire logic       clk,
	output logic [5:0]      reg_addr,
	output logic            reg_wr_en,
	output logic [7:0]      reg_wr_data,
	input  wire logic [7:0] reg_rd_data
);
	import rdf_pkg::*;
	initial begin
		reg_addr    = 6'h00;
		reg_wr_en   = 1'b0;
		reg_wr_data = 8'h00;
	end
	// One-cycle write strobe launched off the falling edge
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		if (a == ADDR_STATE_MACHINE_CONFIG_ONE && d[1:0] == 2'h3) d[1:0] = 2'h2;
		@(negedge clk);
		reg_addr    <= a;
		reg_wr_en   <= 1'b1;
		reg_wr_data <= d;
		@(negedge clk);
		reg_wr_en   <= 1'b0;
		reg_wr_data <= ~d; // Stale data never lingers
	endtask : wr
	// Read data is registered, so take it one cycle later
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr <= a;
		@(negedge clk);
		d = reg_rd_data;
	endtask : rd
endmodule : rdf_host_model

// *** rdf_pkg.sv ***
// Constants for the deviation and radio state machine configuration bank
package rdf_pkg;
	// Register addresses on the serial control port
	localparam logic [5:0] ADDR_FREQUENCY_DEVIATION_SETTING = 6'h15;
	localparam logic [5:0] ADDR_STATE_MACHINE_CONFIG_ONE    = 6'h17;
	localparam logic [5:0] ADDR_STATE_MACHINE_CONFIG_ZERO   = 6'h18;
	localparam int         ADDR_W                           = 6;
	// Field positions
	localparam int DEV_E_LSB      = 4;
	localparam int DEV_M_LSB      = 0;
	localparam int TXOFF_LSB      = 0;
	localparam int AUTOCAL_LSB    = 4;
	localparam int POWER_ON_TIMEOUT_LSB = 2;
	// Reset values
	localparam logic [2:0] DEV_E_RST      = 3'h4;
	localparam logic [2:0] DEV_M_RST      = 3'h7;
	localparam logic [1:0] TXOFF_RST      = 2'h0;
	localparam logic [1:0] AUTOCAL_RST    = 2'h0;
	localparam logic [1:0] POWER_ON_TIMEOUT_RST = 2'h2;
	// Deviation mantissa hidden leading one
	localparam logic [3:0] DEV_M_IMPLICIT = 4'h8;
	// Ripple counter and expiry counts
	localparam int         RIPPLE_W  = 6;
	localparam int         EXPIRE_W  = 9;
	localparam logic [8:0] EXPIRE_0  = 9'h001;
	localparam logic [8:0] EXPIRE_1  = 9'h010;
	localparam logic [8:0] EXPIRE_2  = 9'h040;
	localparam logic [8:0] EXPIRE_3  = 9'h100;
	// Count value at which mode 3 calibrates, so one calibration per four transmit-to-idle moves
	localparam logic [1:0] CAL_EVERY_LAST = 2'h3;

	// Next state after a packet, encoded as the after-transmit field
	typedef enum logic [1:0] {
		RDF_NEXT_IDLE  = 2'h0,
		RDF_NEXT_FSTX  = 2'h1,
		RDF_NEXT_TX    = 2'h2,
		RDF_NEXT_UNDEF = 2'h3
	} rdf_next_t;

	// Auto calibration modes
	typedef enum logic [1:0] {
		RDF_CAL_NEVER    = 2'h0,
		RDF_CAL_TO_TX    = 2'h1,
		RDF_CAL_TO_IDLE  = 2'h2,
		RDF_CAL_FOURTH   = 2'h3
	} rdf_cal_t;
endpackage : rdf_pkg

// *** tb.sv ***
// Self-checking testbench for the configuration bank
`timescale 1ns/10ps
module tb;
	import rdf_pkg::*;
	logic        clk          = 1'b0;
	logic        rst          = 1'b1;
	logic        msk_select   = 1'b0;
	logic        xosc_running = 1'b0;
	logic [4:0]  ev           = 5'h00;
	logic [5:0]  reg_addr;
	logic        reg_wr_en;
	logic [7:0]  reg_wr_data;
	logic [7:0]  reg_rd_data;
	logic [7:0]  rv;
	logic [10:0] deviation_steps;
	logic [2:0]  msk_phase_fraction;
	rdf_next_t   after_transmit_next_state;
	logic        next_state_valid;
	logic        synth_calibrate;
	logic        chip_ready_low;
	int          n_mismatch   = 0;
	int          tests_run    = 0;
	always #5 clk = ~clk;
	rdf_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data));
	rdf_config_bank DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .msk_select(msk_select),
		.packet_tx_done(ev[0]), .idle_to_tx(ev[1]), .tx_to_idle(ev[2]),
		.calibrate_strobe(ev[3]), .sleep_enter(ev[4]), .xosc_running(xosc_running),
		.deviation_steps(deviation_steps), .msk_phase_fraction(msk_phase_fraction),
		.after_transmit_next_state(after_transmit_next_state),
		.next_state_valid(next_state_valid), .synth_calibrate(synth_calibrate),
		.chip_ready_low(chip_ready_low));
	task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// One-cycle event pulse; registered answers are visible on return
	task automatic pulse(input int b);
		@(negedge clk);
		ev[b] = 1'b1;
		@(negedge clk);
		ev = 5'h00;
	endtask : pulse
	task automatic test_done;
		$display("Counts run %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : test_done
	task automatic t_reset;
		host.rd(ADDR_FREQUENCY_DEVIATION_SETTING, rv);
		chk("dev_reg", 11'h047, 11'(rv));
		host.rd(ADDR_STATE_MACHINE_CONFIG_ONE, rv);
		chk("sm1_reg", 11'h000, 11'(rv));
		host.rd(ADDR_STATE_MACHINE_CONFIG_ZERO, rv);
		chk("sm0_reg", 11'h008, 11'(rv));
		chk("dev_steps", 11'h0f0, deviation_steps);
		chk("ready", 11'h001, 11'(chip_ready_low));
		$display("Test reset done");
	endtask : t_reset
	task automatic t_regs;
		host.wr(ADDR_FREQUENCY_DEVIATION_SETTING, 8'hff);
		host.rd(ADDR_FREQUENCY_DEVIATION_SETTING, rv);
		chk("dev_rsv", 11'h077, 11'(rv));
		chk("dev_max", 11'h780, deviation_steps);
		msk_select = 1'b1;
		@(negedge clk);
		chk("msk_frac", 11'h007, 11'(msk_phase_fraction));
		chk("msk_dev", 11'h000, deviation_steps);
		msk_select = 1'b0;
		host.wr(ADDR_STATE_MACHINE_CONFIG_ONE, 8'hfe);
		host.rd(ADDR_STATE_MACHINE_CONFIG_ONE, rv);
		chk("sm1_rsv", 11'h002, 11'(rv));
		host.wr(ADDR_STATE_MACHINE_CONFIG_ZERO, 8'hff);
		host.rd(ADDR_STATE_MACHINE_CONFIG_ZERO, rv);
		chk("sm0_rsv", 11'h03c, 11'(rv));
		host.wr(6'h16, 8'hff);
		host.rd(6'h16, rv);
		chk("unmapped", 11'h000, 11'(rv));
		$display("Test registers done");
	endtask : t_regs
	task automatic t_next;
		for (int s = 0; s < 3; s++) begin
			host.wr(ADDR_STATE_MACHINE_CONFIG_ONE, 8'(s));
			pulse(0);
			chk("nxt_valid", 11'h001, 11'(next_state_valid));
			chk("nxt_state", 11'(s), 11'(after_transmit_next_state));
		end
		$display("Test next state done");
	endtask : t_next
	// Mode, event and expected calibration per row; timeout held at 1
	task automatic t_cal;
		int md [7] = '{0, 0, 0, 1, 1, 2, 2};
		int bt [7] = '{3, 1, 2, 1, 2, 2, 1};
		int ex [7] = '{1, 0, 0, 1, 0, 1, 0};
		for (int i = 0; i < 7; i++) begin
			host.wr(ADDR_STATE_MACHINE_CONFIG_ZERO, {2'h0, 2'(md[i]), 4'h4});
			pulse(bt[i]);
			chk("cal", 11'(ex[i]), 11'(synth_calibrate));
		end
		host.wr(ADDR_FREQUENCY_DEVIATION_SETTING, 8'h12);
		pulse(4);
		host.rd(ADDR_STATE_MACHINE_CONFIG_ZERO, rv);
		chk("keep_po", 11'h004, 11'(rv));
		host.rd(ADDR_FREQUENCY_DEVIATION_SETTING, rv);
		chk("dev_sleep", 11'h047, 11'(rv));
		host.wr(ADDR_STATE_MACHINE_CONFIG_ZERO, 8'h34);
		for (int i = 1; i < 9; i++) begin
			pulse(2);
			chk("cal4", 11'(i % 4 == 0), 11'(synth_calibrate));
		end
		$display("Test calibration done");
	endtask : t_cal
	task automatic t_po;
		int n;
		int lo;
		for (int t = 0; t < 4; t++) begin
			host.wr(ADDR_STATE_MACHINE_CONFIG_ZERO, 8'(t << 2));
			lo = (t == 0) ? 64 : 64 << (2 * t + 2);
			xosc_running = 1'b1;
			n = 0;
			while (chip_ready_low === 1'b1 && n < 17000) begin
				@(negedge clk);
				n++;
			end
			chk("po_wait", 11'h001, 11'(n >= lo && n <= lo + 5));
			xosc_running = 1'b0;
			repeat (4) @(negedge clk);
			chk("po_idle", 11'h001, 11'(chip_ready_low));
		end
		host.wr(ADDR_STATE_MACHINE_CONFIG_ZERO, 8'h08);
		$display("Test power-on timeout done");
	endtask : t_po
	initial begin
		repeat (4) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_regs();
		t_next();
		t_cal();
		t_po();
		test_done();
	end
	// Watchdog sized well above the longest timeout sweep
	initial begin
		repeat (40000) @(negedge clk);
		n_mismatch++;
		test_done();
	end
endmodule : tb
